// file: inc/scu_pkg.sv
// Purpose: Shared constants and types for the serial comm unit
// Assumes: 8-bit characters, 16x oversampling
// Notes:   Clock source encodings follow the mode and clock enable bits
package scu_pkg;
	localparam int DATA_W      = 8;
	localparam int OVS         = 16;
	localparam int OVS_W       = 4;
	localparam int PRE_W       = 2;
	localparam int DIV_W       = 8;
	localparam int BIT_W       = 4;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID  = 4'h7;
	localparam logic [3:0] OVS_HALF = 4'h8;
	localparam int BUF_DEPTH   = 2;

	typedef enum logic [1:0] {
		SCU_TX_IDLE  = 2'b00,
		SCU_TX_START = 2'b01,
		SCU_TX_DATA  = 2'b10,
		SCU_TX_STOP  = 2'b11
	} scu_tx_state_t;

	typedef enum logic [1:0] {
		SCU_RX_IDLE  = 2'b00,
		SCU_RX_START = 2'b01,
		SCU_RX_DATA  = 2'b10,
		SCU_RX_STOP  = 2'b11
	} scu_rx_state_t;
endpackage

// file: design/scu_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes:   Read data come from a register
`timescale 1ns/10ps
module scu_buf2 (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	// Fill side
	input  wire logic                         inValid,
	output logic                              inReady,
	input  wire logic [scu_pkg::DATA_W-1:0]   inData,
	// Drain side
	output logic                              outValid,
	input  wire logic                         outReady,
	output logic      [scu_pkg::DATA_W-1:0]   outData
);
	typedef struct packed {
		logic [scu_pkg::DATA_W-1:0] mem0;
		logic [scu_pkg::DATA_W-1:0] mem1;
		logic [1:0]                 count;
	} scu_buf_t;

	scu_buf_t s_q;
	scu_buf_t s_d;
	logic     push;
	logic     pop;

	assign inReady  = (s_q.count != 2'h2);
	assign outValid = (s_q.count != 2'h0);
	assign outData  = s_q.mem0;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_comb begin
		s_d = s_q;
		if (pop) begin
			s_d.mem0 = s_q.mem1;
		end
		if (push) begin
			if (s_q.count == 2'h0 || (s_q.count == 2'h1 && pop)) begin
				s_d.mem0 = inData;
			end else begin
				s_d.mem1 = inData;
			end
		end
		s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // scu_buf2

// file: design/scu_serial_comm_unit.sv
// Purpose: Asynchronous serial transceiver, full duplex, double buffered
// Assumes: Control bits are plain ports; line pins synchronous to sys_clk
// Notes:   External clock is sampled as a 16x bit-rate enable
`timescale 1ns/10ps
module scu_serial_comm_unit (
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Mode and control
	input  wire logic                        commModeSync,
	input  wire logic                        clockSourceSelLo,
	input  wire logic                        clockSourceSelHi,
	input  wire logic                        txEnableBit,
	input  wire logic                        rxEnableBit,
	input  wire logic                        txEmptyIrqEnable,
	input  wire logic                        txEndIrqEnable,
	input  wire logic                        rxIrqEnable,
	input  wire logic                        parityEnable,
	input  wire logic                        parityOdd,
	input  wire logic                        twoStopBits,
	input  wire logic [scu_pkg::PRE_W-1:0]   baudPrescale,
	input  wire logic [scu_pkg::DIV_W-1:0]   baudDivisor,
	// Transmit data buffer write
	input  wire logic                        txWrite,
	input  wire logic [scu_pkg::DATA_W-1:0]  txWriteData,
	// Receive data buffer read
	input  wire logic                        rxRead,
	output logic      [scu_pkg::DATA_W-1:0]  rxDataBuffer,
	// Status flag clears
	input  wire logic                        clearOverrun,
	input  wire logic                        clearFraming,
	input  wire logic                        clearParity,
	input  wire logic                        clearRxFull,
	// Status flags
	output logic                             txBufferEmptyFlag,
	output logic                             txEndFlag,
	output logic                             rxFullFlag,
	output logic                             overrunErrorFlag,
	output logic                             framingErrorFlag,
	output logic                             parityErrorFlag,
	// Interrupt requests
	output logic                             txEmptyIrq,
	output logic                             txEndIrq,
	output logic                             rxFullIrq,
	output logic                             rxErrorIrq,
	// Line pins
	output logic                             txd,
	input  wire logic                        rxd,
	input  wire logic                        serialClockIn,
	output logic                             serialClockOut,
	output logic                             serialClockOe
);
	typedef struct packed {
		logic [scu_pkg::DATA_W-1:0]  txBuf;
		logic                        tdEmpty;
		logic                        tx_end_flag;
		scu_pkg::scu_tx_state_t      txSt;
		logic [scu_pkg::DATA_W:0]    txShift;
		logic [scu_pkg::BIT_W-1:0]   txCnt;
		logic [scu_pkg::OVS_W-1:0]   txTick;
		logic                        txLine;
		logic                        sckOut;
		scu_pkg::scu_rx_state_t      rxSt;
		logic [scu_pkg::DATA_W:0]    rxShift;
		logic [scu_pkg::BIT_W-1:0]   rxCnt;
		logic [scu_pkg::OVS_W-1:0]   rxTick;
		logic [scu_pkg::DATA_W-1:0]  rxBuf;
		logic                        rdFull;
		logic                        overrun_error_flag;
		logic                        framing_error_flag;
		logic                        parity_error_flag;
		logic                        rxFullIrq;
		logic                        rxErrIrq;
		logic                        txEmptyIrq;
		logic                        txEndIrq;
		logic [scu_pkg::DIV_W+5:0]   baudCnt;
		logic                        extClkPrev;
	} scu_state_t;

	scu_state_t s_q;
	scu_state_t s_d;

	logic                       extClkSel;
	logic                       ovsTick;
	logic [scu_pkg::DIV_W+5:0]  baudLimit;
	logic                       bufOutValid;
	logic                       bufOutReady;
	logic                       bufInReady;
	logic [scu_pkg::DATA_W-1:0] bufOutData;
	logic                       rxParityOk;
	logic                       errAny;

	// Even parity over the data, inverted for odd
	function automatic logic parity_of(input logic [scu_pkg::DATA_W-1:0] d,
		input logic odd);
		parity_of = (^d) ^ odd;
	endfunction

	// Async mode: CLOCK_SOURCE_SEL_HI set selects external clock input
	assign extClkSel = !commModeSync && clockSourceSelHi;
	// Prescaler n scales divisor by 4^n, 32 clocks per count
	assign baudLimit = ({6'h00, baudDivisor} + 14'h0001)
		<< (2 * baudPrescale + 1);
	// Either the internal 16x tick or an external 16x clock edge
	assign ovsTick = extClkSel ? (serialClockIn && !s_q.extClkPrev)
		: (s_q.baudCnt == baudLimit - 14'h0001);

	// Transmit buffer: a write while full is dropped, since bufInReady is not brought out to a port
	scu_buf2 u_txbuf (
		.sys_clk  (sys_clk),
		// Disable drops queued words so the empty flag reads one
		.rst      (rst || !txEnableBit),
		.inValid  (txWrite && txEnableBit),
		.inReady  (bufInReady),
		.inData   (txWriteData),
		.outValid (bufOutValid),
		.outReady (bufOutReady),
		.outData  (bufOutData)
	);
	// Drain one word into the data buffer slot whenever it is empty
	assign bufOutReady = s_q.tdEmpty && txEnableBit;

	assign errAny     = s_q.overrun_error_flag || s_q.framing_error_flag || s_q.parity_error_flag;
	assign rxParityOk = !parityEnable
		|| (parity_of(s_q.rxShift[scu_pkg::DATA_W-1:0], parityOdd)
		== s_q.rxShift[scu_pkg::DATA_W]);

	always_comb begin
		s_d = s_q;
		s_d.rxFullIrq  = 1'b0;
		s_d.rxErrIrq   = 1'b0;
		s_d.txEmptyIrq = 1'b0;
		s_d.txEndIrq   = 1'b0;
		s_d.extClkPrev = serialClockIn;
		s_d.baudCnt = (ovsTick || extClkSel) ? '0 : s_q.baudCnt + 14'h0001;

		// Buffer to data slot clears the empty flag
		if (bufOutValid && bufOutReady) begin
			s_d.txBuf   = bufOutData;
			s_d.tdEmpty = 1'b0;
		end

		if (ovsTick) begin
			s_d.txTick = s_q.txTick + 4'h1;
			// Rising edge mid-bit: high in second half of bit
			s_d.sckOut = (s_q.txTick >= OVS_MIDP1());
		end

		if (ovsTick && s_q.txTick == scu_pkg::OVS_LAST) begin
			case (s_q.txSt)
				scu_pkg::SCU_TX_IDLE: begin
					s_d.txLine = 1'b1;
					if (!s_q.tdEmpty && txEnableBit) begin
						s_d.txShift = {parity_of(s_q.txBuf, parityOdd),
							s_q.txBuf};
						s_d.tdEmpty = 1'b1;
						s_d.txEmptyIrq = txEmptyIrqEnable;
						s_d.tx_end_flag    = 1'b0;
						s_d.txLine  = 1'b0;
						s_d.txSt    = scu_pkg::SCU_TX_START;
					end
				end
				scu_pkg::SCU_TX_START, scu_pkg::SCU_TX_DATA: begin
					if (s_q.txSt == scu_pkg::SCU_TX_START
						&& s_q.txCnt == '1) begin
						// Back-to-back frame: start bit before bit 0
						s_d.txLine = 1'b0;
						s_d.txCnt  = '0;
					end else begin
						s_d.txLine  = s_q.txShift[0];
						s_d.txShift = s_q.txShift >> 1;
						s_d.txCnt   = s_q.txCnt + 4'h1;
						if (s_q.txCnt == (parityEnable ? 4'h8 : 4'h7)) begin
							s_d.txSt  = scu_pkg::SCU_TX_STOP;
							s_d.txCnt = '0;
						end else begin
							s_d.txSt  = scu_pkg::SCU_TX_DATA;
						end
						if (s_q.txSt == scu_pkg::SCU_TX_START) begin
							s_d.txCnt = 4'h1;
						end
					end
				end
				default: begin
					s_d.txLine = 1'b1;
					s_d.txCnt  = s_q.txCnt + 4'h1;
					if (s_q.txCnt == {3'h0, twoStopBits}) begin
						s_d.txCnt = '0;
						if (!s_q.tdEmpty && txEnableBit) begin
							s_d.txShift = {parity_of(s_q.txBuf, parityOdd),
								s_q.txBuf};
							s_d.tdEmpty    = 1'b1;
							s_d.txEmptyIrq = txEmptyIrqEnable;
							s_d.txSt       = scu_pkg::SCU_TX_START;
							// All ones marks a start bit still owed
							s_d.txCnt      = '1;
						end else begin
							s_d.tx_end_flag     = 1'b1;
							s_d.txEndIrq = txEndIrqEnable;
							s_d.txSt     = scu_pkg::SCU_TX_IDLE;
						end
					end
				end
			endcase
		end

		// Receiver, gated by enable and by pending errors
		if (ovsTick && rxEnableBit) begin
			s_d.rxTick = s_q.rxTick + 4'h1;
			case (s_q.rxSt)
				scu_pkg::SCU_RX_IDLE: begin
					s_d.rxTick = '0;
					if (!rxd && rxEnableBit && !errAny) begin
						s_d.rxSt = scu_pkg::SCU_RX_START;
					end
				end
				scu_pkg::SCU_RX_START: begin
					if (s_q.rxTick == scu_pkg::OVS_MID) begin
						s_d.rxTick = '0;
						s_d.rxCnt  = '0;
						s_d.rxSt   = rxd ? scu_pkg::SCU_RX_IDLE
							: scu_pkg::SCU_RX_DATA;
					end
				end
				scu_pkg::SCU_RX_DATA: begin
					if (s_q.rxTick == scu_pkg::OVS_LAST) begin
						s_d.rxShift = parityEnable
							? {rxd, s_q.rxShift[scu_pkg::DATA_W:1]}
							: {1'b0, rxd, s_q.rxShift[scu_pkg::DATA_W-1:1]};
						s_d.rxCnt = s_q.rxCnt + 4'h1;
						if (s_q.rxCnt == (parityEnable ? 4'h8 : 4'h7)) begin
							s_d.rxSt = scu_pkg::SCU_RX_STOP;
						end
					end
				end
				default: begin
					if (s_q.rxTick == scu_pkg::OVS_LAST) begin
						s_d.rxSt = scu_pkg::SCU_RX_IDLE;
						if (s_q.rdFull) begin
							s_d.overrun_error_flag = 1'b1;
						end else begin
							s_d.rxBuf = s_q.rxShift[scu_pkg::DATA_W-1:0];
						end
						if (!rxParityOk) begin
							s_d.parity_error_flag = 1'b1;
						end
						if (!rxd) begin
							s_d.framing_error_flag = 1'b1;
						end
						if (!s_q.rdFull && rxParityOk && rxd) begin
							s_d.rdFull    = 1'b1;
							s_d.rxFullIrq = rxIrqEnable;
						end
						// Full flag untouched by errors
						s_d.rxErrIrq = rxIrqEnable
							&& (s_q.rdFull || !rxParityOk || !rxd);
					end
				end
			endcase
		end

		// Clears lose to a set in the same cycle
		if (rxRead && !s_d.rxFullIrq && !(s_d.rdFull && !s_q.rdFull)) begin
			s_d.rdFull = 1'b0;
		end
		if (clearRxFull && !(s_d.rdFull && !s_q.rdFull)) begin
			s_d.rdFull = 1'b0;
		end
		if (clearOverrun && s_d.overrun_error_flag == s_q.overrun_error_flag) begin
			s_d.overrun_error_flag = 1'b0;
		end
		if (clearFraming && s_d.framing_error_flag == s_q.framing_error_flag) begin
			s_d.framing_error_flag = 1'b0;
		end
		if (clearParity && s_d.parity_error_flag == s_q.parity_error_flag) begin
			s_d.parity_error_flag = 1'b0;
		end
		if (!txEnableBit) begin
			s_d.tdEmpty = 1'b1;
			s_d.tx_end_flag    = 1'b1;
			s_d.txSt    = scu_pkg::SCU_TX_IDLE;
			s_d.txLine  = 1'b1;
		end
		if (!rxEnableBit) begin
			s_d.rxSt = scu_pkg::SCU_RX_IDLE;
		end
	end

	// Mid point plus one: edge lands in bit centre
	function automatic logic [3:0] OVS_MIDP1();
		OVS_MIDP1 = scu_pkg::OVS_HALF;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q         <= '0;
			s_q.tdEmpty <= 1'b1;
			s_q.tx_end_flag    <= 1'b1;
			s_q.txLine  <= 1'b1;
			s_q.txSt    <= scu_pkg::SCU_TX_IDLE;
			s_q.rxSt    <= scu_pkg::SCU_RX_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rxDataBuffer      = s_q.rxBuf;
	assign txBufferEmptyFlag = s_q.tdEmpty && !bufOutValid;
	assign txEndFlag         = s_q.tx_end_flag;
	assign rxFullFlag        = s_q.rdFull;
	assign overrunErrorFlag  = s_q.overrun_error_flag;
	assign framingErrorFlag  = s_q.framing_error_flag;
	assign parityErrorFlag   = s_q.parity_error_flag;
	assign txEmptyIrq        = s_q.txEmptyIrq;
	assign txEndIrq          = s_q.txEndIrq;
	assign rxFullIrq         = s_q.rxFullIrq;
	assign rxErrorIrq        = s_q.rxErrIrq;
	assign txd               = s_q.txLine;
	// Clock driven out only on internal source with CLOCK_SOURCE_SEL_LO set
	assign serialClockOe     = !extClkSel && clockSourceSelLo;
	assign serialClockOut    = s_q.sckOut;
endmodule // scu_serial_comm_unit

// file: tb/scu_checker.sv
// Purpose: Port assertions for the serial comm unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Irq pulses may trail their flag by one cycle
`timescale 1ns/10ps
module scu_checker (
	// Clock and reset
	input wire logic			sys_clk,
	input wire logic			rst,
	// Controls
	input wire logic			txEnableBit,
	input wire logic			rxEnableBit,
	input wire logic			txEmptyIrqEnable,
	input wire logic			txEndIrqEnable,
	input wire logic			rxIrqEnable,
	input wire logic			txWrite,
	input wire logic			rxRead,
	input wire logic			clearOverrun,
	input wire logic			clearFraming,
	input wire logic			clearParity,
	input wire logic			clearRxFull,
	// Status
	input wire logic [scu_pkg::DATA_W-1:0]	rxDataBuffer,
	input wire logic			txBufferEmptyFlag,
	input wire logic			txEndFlag,
	input wire logic			rxFullFlag,
	input wire logic			overrunErrorFlag,
	input wire logic			framingErrorFlag,
	input wire logic			parityErrorFlag,
	// Irqs and line
	input wire logic			txEmptyIrq,
	input wire logic			txEndIrq,
	input wire logic			rxFullIrq,
	input wire logic			rxErrorIrq,
	input wire logic			txd
);
	wire logic errs = overrunErrorFlag | framingErrorFlag | parityErrorFlag;
	wire logic clr = clearOverrun | clearFraming | clearParity | clearRxFull
		| rxRead;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_txOff; !txEnableBit [*2] |-> txBufferEmptyFlag; endproperty
	a_txOff: assert property (p_txOff) else $error("empty not forced");
	property p_rxOff; !rxEnableBit && !$past(rxEnableBit) && !$past(clr) |->
		$stable({errs, rxFullFlag, parityErrorFlag, rxDataBuffer}); endproperty
	a_rxOff: assert property (p_rxOff) else $error("rx state moved");
	property p_wr;
		txWrite && txEnableBit && txBufferEmptyFlag |=> !txBufferEmptyFlag;
	endproperty
	a_wr: assert property (p_wr) else $error("write kept empty");
	property p_txIrq; $rose(txBufferEmptyFlag) && txEnableBit &&
		txEmptyIrqEnable |-> ##[0:1] txEmptyIrq; endproperty
	a_txIrq: assert property (p_txIrq) else $error("no empty irq");
	property p_endIrq;
		$rose(txEndFlag) && txEndIrqEnable |-> ##[0:1] txEndIrq;
	endproperty
	a_endIrq: assert property (p_endIrq) else $error("no end irq");
	property p_mark; !txd |-> !txEndFlag; endproperty
	a_mark: assert property (p_mark) else $error("low after end");
	property p_rxIrq; $rose(rxFullFlag) && rxIrqEnable |-> ##[0:1] rxFullIrq;
	endproperty
	a_rxIrq: assert property (p_rxIrq) else $error("no full irq");
	property p_errIrq; $rose(errs) && rxIrqEnable |-> ##[0:1] rxErrorIrq;
	endproperty
	a_errIrq: assert property (p_errIrq) else $error("no err irq");
	property p_ovr;
		$rose(overrunErrorFlag) |-> rxFullFlag && $stable(rxDataBuffer);
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun loaded");
	property p_read; rxRead |=> !rxFullFlag; endproperty
	a_read: assert property (p_read) else $error("full not cleared");
	property p_block; errs && !clr |=> $stable(rxDataBuffer); endproperty
	a_block: assert property (p_block) else $error("rx while error");
	c_txi: cover property (txEmptyIrq);
	c_ovr: cover property ($rose(overrunErrorFlag));
	c_eri: cover property (rxErrorIrq);
endmodule // scu_checker
bind scu_serial_comm_unit scu_checker u_chk (.*);

// file: tb/scu_line_partner.sv
// Purpose: Remote serial partner on the line pins
// Assumes: Bit period of BIT clocks, 8 data bits
// Notes:   Decodes device frames without parity only
`timescale 1ns/10ps
module scu_line_partner #(
	parameter int BIT = 32
) (
	// Clock
	input wire logic	sys_clk,
	// Line
	input wire logic	txd,
	output logic		rxd
);
	logic [7:0] got[$];
	initial rxd = 1'b1;
	// Parity slot doubles as first stop when parity is off
	task automatic send(input logic [7:0] d, input logic par, stp);
		logic [10:0] f;
		f = {stp, par, d, 1'b0};
		for (int i = 0; i < 12; i++) begin
			rxd <= (i < 11) ? f[i] : 1'b1;
			repeat (BIT) @(posedge sys_clk);
		end
	endtask
	// Mid-bit sampling keeps clear of edge jitter
	always begin : rxMon
		logic [7:0] d;
		@(negedge txd);
		repeat (BIT / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge sys_clk);
			d[i] = txd;
		end
		repeat (BIT) @(posedge sys_clk);
		if (txd) got.push_back(d);
	end
endmodule // scu_line_partner

// file: tb/testbench.sv
// Purpose: Self-checking bench for the serial comm unit
// Assumes: Divisor 0, prescale 0 give a 32-cycle bit
// Notes:   Transmit runs 8N1 only; the partner cannot decode parity
`timescale 1ns/10ps
module testbench;
	localparam int BIT = 32;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clockSourceSelLo = 1'b1;
	logic clockSourceSelHi = 1'b0;
	logic serialClockIn = 1'b0;
	logic txEnableBit = 1'b1;
	logic rxEnableBit = 1'b1;
	logic txEmptyIrqEnable = 1'b1;
	logic txEndIrqEnable = 1'b1;
	logic rxIrqEnable = 1'b1;
	logic parityEnable = 1'b0;
	logic parityOdd = 1'b0;
	logic [scu_pkg::DIV_W-1:0] baudDivisor = 8'h00;
	logic txWrite = 1'b0;
	logic rxRead = 1'b0;
	logic [scu_pkg::DATA_W-1:0] txWriteData = 8'h00;
	logic clearOverrun = 1'b0;
	logic clearFraming = 1'b0;
	logic clearParity = 1'b0;
	logic clearRxFull = 1'b0;
	logic [scu_pkg::DATA_W-1:0] rxDataBuffer;
	logic txBufferEmptyFlag, txEndFlag, rxFullFlag;
	logic overrunErrorFlag, framingErrorFlag, parityErrorFlag;
	logic txEmptyIrq, txEndIrq, rxFullIrq, rxErrorIrq;
	logic txd, rxd, serialClockOut, serialClockOe;
	int miscompares = 0;
	int checks = 0;
	wire logic [7:0] st = {1'b0, txd, txBufferEmptyFlag, txEndFlag,
		rxFullFlag, overrunErrorFlag, framingErrorFlag, parityErrorFlag};
	scu_serial_comm_unit DUT (.*, .commModeSync(1'b0),
		.twoStopBits(1'b0), .baudPrescale(2'h0));
	scu_line_partner #(.BIT(BIT)) P (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
	always #2.5 sys_clk = ~sys_clk;
	// External 16x clock runs free, reset and setup included
	always @(posedge sys_clk) serialClockIn <= ~serialClockIn;
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, a);
		checks++;
		if (a !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, a);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic fail(input string nm);
		miscompares++;
		$display("[ERR] %s expected 1 seen 0", nm);
		results();
	endtask
	task automatic waitHi(ref logic s, input int n);
		int i;
		for (i = 0; i < n && s !== 1'b1; i++)
			tick(1);
		if (i == n) fail("flag wait");
	endtask
	task automatic clr();
		{clearOverrun, clearFraming, clearParity, clearRxFull} <= 4'hf;
		tick(1);
		{clearOverrun, clearFraming, clearParity, clearRxFull} <= 4'h0;
	endtask
	task automatic rd();
		rxRead <= 1'b1;
		tick(1);
		rxRead <= 1'b0;
		tick(1);
	endtask
	task automatic tTx();
		int i;
		chk("idle", 16'h0070, {8'h00, st});
		txWriteData <= 8'ha5;
		txWrite <= 1'b1;
		tick(1);
		txWriteData <= 8'h3c;
		tick(1);
		txWrite <= 1'b0;
		#1 chk("empty", 16'h0000, {15'h0, txBufferEmptyFlag});
		for (i = 0; i < 1000 && P.got.size() < 2; i++)
			tick(1);
		if (i == 1000) fail("tx words");
		chk("tx words", 16'ha53c, {P.got[0], P.got[1]});
		waitHi(txEndFlag, 64);
		chk("mark", 16'h0003, {14'h0, txd, txEndFlag});
		$display("tx test done");
	endtask
	task automatic tRx();
		P.send(8'h5a, 1'b1, 1'b1);
		waitHi(rxFullFlag, 64);
		chk("rx good", 16'h5a78, {rxDataBuffer, st});
		rd();
		chk("read", 16'h5a70, {rxDataBuffer, st});
		// Odd parity: four ones need a 1, send 0
		parityEnable <= 1'b1;
		parityOdd <= 1'b1;
		P.send(8'h96, 1'b0, 1'b1);
		waitHi(parityErrorFlag, 64);
		chk("parity", 16'h9671, {rxDataBuffer, st});
		rxEnableBit <= 1'b0;
		tick(6);
		chk("rx off", 16'h9671, {rxDataBuffer, st});
		rxEnableBit <= 1'b1;
		clr();
		// Even parity correct, stop low
		parityOdd <= 1'b0;
		P.send(8'h0f, 1'b0, 1'b0);
		waitHi(framingErrorFlag, 64);
		chk("framing", 16'h0f72, {rxDataBuffer, st});
		clr();
		parityEnable <= 1'b0;
		$display("rx test done");
	endtask
	task automatic tOverrun();
		P.send(8'h11, 1'b1, 1'b1);
		P.send(8'h22, 1'b1, 1'b1);
		waitHi(overrunErrorFlag, 64);
		chk("overrun", 16'h117c, {rxDataBuffer, st});
		P.send(8'h33, 1'b1, 1'b1);
		tick(40);
		chk("blocked", 16'h117c, {rxDataBuffer, st});
		clr();
		P.send(8'h44, 1'b1, 1'b1);
		waitHi(rxFullFlag, 64);
		chk("resume", 16'h4478, {rxDataBuffer, st});
		rd();
		$display("overrun test done");
	endtask
	task automatic tExt();
		clockSourceSelHi <= 1'b1;
		tick(2);
		P.send(8'hc3, 1'b1, 1'b1);
		waitHi(rxFullFlag, 64);
		chk("ext clk", 16'hc378, {rxDataBuffer, st});
		chk("ext oe", 16'h0000, {15'h0, serialClockOe});
		rd();
		clockSourceSelHi <= 1'b0;
		tick(2);
		$display("ext clock test done");
	endtask
	task automatic tTxOff();
		txWriteData <= 8'h81;
		txWrite <= 1'b1;
		tick(1);
		txWrite <= 1'b0;
		txEnableBit <= 1'b0;
		clockSourceSelLo <= 1'b0;
		tick(2);
		chk("tx off", 16'h0002, {14'h0, txBufferEmptyFlag, serialClockOe});
		txEnableBit <= 1'b1;
		clockSourceSelLo <= 1'b1;
		tick(2);
		chk("clk oe", 16'h0001, {15'h0, serialClockOe});
		$display("tx off test done");
	endtask
	initial begin
		tick(5);
		rst <= 1'b0;
		tick(1);
		tTx();
		tRx();
		tOverrun();
		tExt();
		tTxOff();
		results();
	end
endmodule // testbench
